// ---- media_decode_command_unit.sv ----
// Purpose: media command interpreter: parses command words, feeds a decode core
// Assumes: decode core on the same clock; vblank arrives from a pin
// Notes:   the deflate, jpeg, png and avi cores themselves sit outside this unit
//
// Contract
// - raw decompress: opcode, destination, inline bytes
// - selectable decompress: opcode, destination, options, bytes
// - selectable source: stream buffer, flash, else inline
// - image load: opcode, destination, options, bytes
// - jpeg: mono gives luminance, else color16
// - png colour type mapping, type 4 rejected
// - scale option fills the screen
// - image source: stream buffer, flash, else inline
// - image appends display list unless suppressed
// - png uses top 42K scratch at 0xf5800
// - stream setup: opcode, start, size sets buffer
// - play video: opcode, options, optional inline data
// - play control: ff exits, 0 pauses, 1 plays
// - playback starts at once, completes at end (playCtrl resets to 0, so a player after reset waits paused until 1 is written)
// - video bitmap at ram start, audio follows
// - blanking sync, overlay and keep-list options
// - audio formats; 16-bit pcm drops low byte
// - video start consumes header from stream
// - video frame decodes next frame to destination
// - read pointer meets write pointer at completion
`timescale 1ns/1ps
`default_nettype none

module media_decode_command_unit
	import media_decode_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// stream buffer and flash word reads
	output logic             memRdReq,
	output logic      [31:0] memRdAddr,
	output logic             memFlashSel,
	input  wire logic [31:0] memRdData,
	input  wire logic        memRdAck,
	// decode core
	output logic             decStart,
	output logic      [2:0]  decKind,
	output logic      [19:0] decDst,
	output logic      [31:0] decAux,
	output logic      [31:0] decWord,
	output logic             decWordValid,
	input  wire logic        decWordReady,
	output logic             decAbort,
	input  wire logic        decDone,
	input  wire logic        imgInfoValid,
	input  wire logic        imgIsPng,
	input  wire logic [2:0]  pngType,
	input  wire logic        pngHasAlpha,
	input  wire logic [1:0]  audioFmt,
	// rendering controls to the core
	output logic      [2:0]  bitmapFormat,
	output logic             scaleToScreen,
	output logic      [1:0]  dlMode,
	output logic             scratchActive,
	output logic      [19:0] scratchAddr,
	output logic             audioOn,
	output logic      [19:0] audioGap,
	output logic             audioDropLow,
	output logic             frameUpdateEn,
	input  wire logic        vblankPin
);

	typedef struct packed {
		logic [2:0]  vbSync;
		logic        vblank;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		state_t      state;
		cmd_t        cmd;
		logic [1:0]  argsLeft;
		logic [1:0]  argIdx;
		logic [31:0] arg0;
		logic [31:0] arg1;
		logic [11:0] cmdFetch;
		logic [15:0][31:0] cmdBuf;
		logic [19:0] gap;
		logic [11:0] cmdRd;
		logic [11:0] cmdWr;
		logic [7:0]  playCtrl;
		logic [19:0] strBase;
		logic [19:0] strSize;
		logic [19:0] strRd;
		logic [19:0] strWr;
		logic [31:0] flashAddr;
		logic        memReq;
		logic [31:0] memAddr;
		logic        flashSel;
		logic        decStart;
		logic [2:0]  decKind;
		logic [19:0] decDst;
		logic [31:0] decAux;
		logic [31:0] decWord;
		logic        decValid;
		logic        decAbort;
		logic [2:0]  fmt;
		logic        scale;
		logic [1:0]  dlMode;
		logic        scratch;
		logic        audio;
		logic        dropLow;
		logic        frameEn;
		logic        err;
		logic        reject;
	} unit_state_t;

	unit_state_t st;
	unit_state_t nxt;

	logic        access;
	logic        streamHasData;
	logic [19:0] strRdInc;
	logic [31:0] opts;
	logic        feedOk;
	logic        cmdAvail;
	logic [31:0] cmdHead;
	logic        cmdFull;
	logic        multiSrc;
	logic        useStream;
	logic        useFlash;
	dec_kind_t   kindOf;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	assign access        = psel && penable;
	assign strRdInc      = st.strRd + 20'h00004;
	assign streamHasData = st.flashSel || (st.strRd != st.strWr);
	assign opts          = (st.cmd == C_PLAY) ? st.arg0 : st.arg1;
	// a paused player neither takes words nor fetches them
	assign feedOk        = !((st.cmd == C_PLAY) && (st.playCtrl == PLAY_PAUSE));

	// words between the committed read pointer and the fetch pointer still belong to the running command
	assign cmdAvail = st.cmdFetch != st.cmdWr;
	assign cmdHead  = st.cmdBuf[st.cmdFetch[5:2]];
	// full is judged against the committed pointer so no word of a running command is overwritten
	assign cmdFull  = (st.cmdWr - st.cmdRd) == 12'h040;

	// source select: stream buffer wins over flash, else inline words
	assign multiSrc  = (st.cmd == C_SELECT) || (st.cmd == C_IMAGE) || (st.cmd == C_PLAY);
	assign useFlash  = multiSrc && !opts[opt_stream_buffer_source] && opts[source_a];
	assign useStream = useFlash || (multiSrc && opts[opt_stream_buffer_source]) ||
		(st.cmd == C_VSTART) || (st.cmd == C_VFRAME);

	// decoder kind for each command
	assign kindOf = (st.cmd == C_IMAGE)  ? K_IMAGE  :
		(st.cmd == C_PLAY)   ? K_VIDEO  :
		(st.cmd == C_VSTART) ? K_VIDHDR :
		(st.cmd == C_VFRAME) ? K_FRAME  : K_DEFLATE;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		nxt          = st;
		nxt.decStart = 1'b0;
		nxt.decAbort = 1'b0;

		// vblank pin: three flops, accepted once the last two agree
		nxt.vbSync = {st.vbSync[1:0], vblankPin};
		if (st.vbSync[1] == st.vbSync[2]) begin
			nxt.vblank = st.vbSync[2];
		end

		// apb: ready one cycle into the access phase, so read data is settled when the master looks
		if (!access) begin
			nxt.pready  = 1'b0;
			nxt.pslverr = 1'b0;
		end
		if (access && !st.pready) begin
			nxt.pready  = 1'b1;
			nxt.pslverr = 1'b0;
			nxt.prdata  = 32'h00000000;
			case (paddr)
				REG_CMD_PUSH: begin
					nxt.pslverr = !pwrite || cmdFull;
				end
				REG_CMD_RDPTR: begin
					nxt.prdata = {20'h00000, st.cmdRd};
				end
				REG_CMD_WRPTR: begin
					nxt.prdata = {20'h00000, st.cmdWr};
				end
				REG_STATUS: begin
					nxt.prdata[ST_BUSY]   = st.state != S_IDLE;
					nxt.prdata[ST_ERROR]  = st.err;
					nxt.prdata[ST_REJECT] = st.reject;
				end
				REG_PLAY_CTRL: begin
					nxt.prdata = {24'h000000, st.playCtrl};
				end
				REG_STREAM_BASE: begin
					nxt.prdata = {12'h000, st.strBase};
				end
				REG_STREAM_SIZE: begin
					nxt.prdata = {12'h000, st.strSize};
				end
				REG_STREAM_RD: begin
					nxt.prdata = {12'h000, st.strRd};
				end
				REG_STREAM_WR: begin
					nxt.prdata = {12'h000, st.strWr};
				end
				REG_FLASH_ADDR: begin
					nxt.prdata = st.flashAddr;
				end
				default: begin
					nxt.pslverr = 1'b1;
				end
			endcase
		end
		// the completing edge: writes land here and ready drops for the next access
		if (access && st.pready) begin
			nxt.pready  = 1'b0;
			nxt.pslverr = 1'b0;
			if (pwrite && !st.pslverr) begin
				case (paddr)
					REG_CMD_PUSH: begin
						nxt.cmdBuf[st.cmdWr[5:2]] = pwdata;
						nxt.cmdWr                 = st.cmdWr + 12'h004;
					end
					REG_PLAY_CTRL: begin
						nxt.playCtrl = pwdata[7:0];
					end
					REG_STREAM_WR: begin
						nxt.strWr = pwdata[19:0];
					end
					REG_FLASH_ADDR: begin
						nxt.flashAddr = pwdata;
					end
					default: begin
					end
				endcase
			end
		end

		// command engine
		unique case (st.state)
			S_IDLE: begin
				if (cmdAvail) begin
					nxt.cmdFetch = st.cmdFetch + 12'h004;
					nxt.argIdx   = 2'h0;
					nxt.err      = 1'b0;
					nxt.reject   = 1'b0;
					nxt.state    = S_ARGS;
					case (cmdHead)
						OP_RAW_DECOMPRESS: begin
							nxt.cmd      = C_RAW;
							nxt.argsLeft = 2'h1;
						end
						OP_SELECT_DECOMPRESS: begin
							nxt.cmd      = C_SELECT;
							nxt.argsLeft = 2'h2;
						end
						OP_IMAGE_LOAD: begin
							nxt.cmd      = C_IMAGE;
							nxt.argsLeft = 2'h2;
						end
						OP_STREAM_SETUP: begin
							nxt.cmd      = C_SETUP;
							nxt.argsLeft = 2'h2;
						end
						OP_PLAY_VIDEO: begin
							nxt.cmd      = C_PLAY;
							nxt.argsLeft = 2'h1;
						end
						OP_VIDEO_START: begin
							nxt.cmd      = C_VSTART;
							nxt.argsLeft = 2'h0;
						end
						OP_VIDEO_FRAME: begin
							nxt.cmd      = C_VFRAME;
							nxt.argsLeft = 2'h2;
						end
						default: begin
							// an unknown word is dropped so the buffer cannot wedge
							nxt.err   = 1'b1;
							nxt.state = S_IDLE;
							nxt.cmdRd = st.cmdFetch + 12'h004;
						end
					endcase
				end
			end
			S_ARGS: begin
				if (st.argsLeft != 2'h0) begin
					if (cmdAvail) begin
						nxt.cmdFetch = st.cmdFetch + 12'h004;
						nxt.argsLeft = st.argsLeft - 2'h1;
						nxt.argIdx   = st.argIdx + 2'h1;
						if (st.argIdx == 2'h0) begin
							nxt.arg0 = cmdHead;
						end else begin
							nxt.arg1 = cmdHead;
						end
					end
				end else if (st.cmd == C_SETUP) begin
					// pointers restart at the base; the host fills from there
					nxt.strBase = st.arg0[19:0];
					nxt.strSize = st.arg1[19:0];
					nxt.strRd   = 20'h00000;
					nxt.strWr   = 20'h00000;
					nxt.state   = S_IDLE;
					nxt.cmdRd   = st.cmdFetch;
				end else begin
					nxt.decStart = 1'b1;
					nxt.decKind  = kindOf;
					nxt.decAux   = opts;
					nxt.decDst   = st.arg0[19:0];
					nxt.decValid = 1'b0;
					nxt.flashSel = useFlash;
					nxt.state    = useStream ? S_STREAM : S_INLINE;
					if (st.cmd == C_IMAGE) begin
						nxt.fmt    = FMT_NONE;
						nxt.scale  = opts[opt_scale_to_screen];
						nxt.dlMode = opts[opt_no_display_list] ? DL_NONE : DL_APPEND;
					end
					if ((st.cmd == C_PLAY) || (st.cmd == C_VSTART)) begin
						nxt.decDst = VIDEO_BITMAP_BASE;
					end
					if (st.cmd == C_PLAY) begin
						nxt.scale  = opts[opt_scale_to_screen];
						nxt.audio  = opts[opt_decode_audio];
						nxt.gap    = opts[opt_decode_audio] ? AUDIO_BUF_BYTES : 20'h00000;
						nxt.dlMode = opts[opt_no_display_list] ? DL_NONE :
							opts[opt_append_to_list] ? DL_APPEND : DL_NEW;
					end
				end
			end
			S_INLINE: begin
				// one word at a time; a bubble after each hand-over keeps the path short
				if (st.decValid && decWordReady) begin
					nxt.decValid = 1'b0;
				end else if (!st.decValid && cmdAvail && feedOk) begin
					nxt.decWord  = cmdHead;
					nxt.decValid = 1'b1;
					nxt.cmdFetch = st.cmdFetch + 12'h004;
				end
			end
			S_STREAM: begin
				if (st.decValid && decWordReady) begin
					nxt.decValid = 1'b0;
				end
				if (st.memReq && memRdAck) begin
					nxt.memReq   = 1'b0;
					nxt.decWord  = memRdData;
					nxt.decValid = 1'b1;
					if (st.flashSel) begin
						nxt.flashAddr = st.flashAddr + 32'h00000004;
					end else begin
						nxt.strRd = (strRdInc >= st.strSize) ? 20'h00000 : strRdInc;
					end
				end else if (!st.memReq && !st.decValid && streamHasData && feedOk) begin
					// request and address stand until the responder acknowledges
					nxt.memReq  = 1'b1;
					nxt.memAddr = st.flashSel ? st.flashAddr : {12'h000, st.strBase + st.strRd};
				end
			end
			default: begin
				nxt.state = S_IDLE;
			end
		endcase

		// image header: pick the bitmap format
		if ((st.cmd == C_IMAGE) && (st.state != S_IDLE) && imgInfoValid) begin
			if (imgIsPng) begin
				nxt.scratch = 1'b1;
				case (pngType)
					3'h0: begin
						nxt.fmt = luminance_8bit_format;
					end
					3'h2: begin
						nxt.fmt = color16_format;
					end
					3'h3: begin
						nxt.fmt = pngHasAlpha ? paletted_argb16_format : paletted_color16_format;
					end
					3'h6: begin
						nxt.fmt = argb_4bit_format;
					end
					default: begin
						// grey with alpha and illegal types are refused
						nxt.fmt    = FMT_NONE;
						nxt.reject = 1'b1;
					end
				endcase
			end else begin
				nxt.fmt = opts[opt_monochrome] ? luminance_8bit_format : color16_format;
			end
		end

		// completion: decoder done, player told to exit, or a refused image
		if ((st.state == S_INLINE) || (st.state == S_STREAM)) begin
			if (decDone || st.reject || ((st.cmd == C_PLAY) && (st.playCtrl == PLAY_EXIT))) begin
				nxt.decAbort = !decDone;
				nxt.state    = S_IDLE;
				nxt.decValid = 1'b0;
				nxt.memReq   = 1'b0;
				nxt.scratch  = 1'b0;
				nxt.audio    = 1'b0;
				nxt.gap      = 20'h00000;
				// words taken so far are committed; inline words left behind by an aborted command stay and are parsed as commands
				nxt.cmdRd    = nxt.cmdFetch;
			end
		end

		// audio and frame pacing
		nxt.dropLow = st.audio && (audioFmt == AUD_PCM16);
		nxt.frameEn = st.vblank || !((st.cmd == C_PLAY) && (st.state != S_IDLE) && opts[opt_blanking_sync]);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; a paused player waits after reset until run is written
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else if (clkEn) begin
			st <= nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register, except the fixed scratchAddr
	assign prdata        = st.prdata;
	assign pready        = st.pready;
	assign pslverr       = st.pslverr;
	assign memRdReq      = st.memReq;
	assign memRdAddr     = st.memAddr;
	assign memFlashSel   = st.flashSel;
	assign decStart      = st.decStart;
	assign decKind       = st.decKind;
	assign decDst        = st.decDst;
	assign decAux        = st.decAux;
	assign decWord       = st.decWord;
	assign decWordValid  = st.decValid;
	assign decAbort      = st.decAbort;
	assign bitmapFormat  = st.fmt;
	assign scaleToScreen = st.scale;
	assign dlMode        = st.dlMode;
	assign scratchActive = st.scratch;
	assign scratchAddr   = PNG_SCRATCH_BASE; // fixed location, no state needed
	assign audioOn       = st.audio;
	assign audioGap      = st.gap;
	assign audioDropLow  = st.dropLow;
	assign frameUpdateEn = st.frameEn;

endmodule : media_decode_command_unit

`default_nettype wire

// ---- media_decode_pkg.sv ----
// Purpose: shared constants and types of the media decode command unit
// Assumes: 32-bit APB register words, 20-bit general RAM byte addresses
// Notes:   option bit positions and register offsets are fixed here only
package media_decode_pkg;

	// command opcodes
	localparam logic [31:0] OP_RAW_DECOMPRESS    = 32'hffffff22;
	localparam logic [31:0] OP_SELECT_DECOMPRESS = 32'hffffff50;
	localparam logic [31:0] OP_IMAGE_LOAD        = 32'hffffff24;
	localparam logic [31:0] OP_STREAM_SETUP      = 32'hffffff39;
	localparam logic [31:0] OP_PLAY_VIDEO        = 32'hffffff3a;
	localparam logic [31:0] OP_VIDEO_START       = 32'hffffff40;
	localparam logic [31:0] OP_VIDEO_FRAME       = 32'hffffff41;

	// option word bit positions
	localparam int opt_monochrome           = 0;
	localparam int opt_color16_output       = 1;
	localparam int opt_scale_to_screen      = 2;
	localparam int opt_no_display_list      = 3;
	localparam int opt_blanking_sync        = 4;
	localparam int opt_decode_audio         = 5;
	localparam int opt_append_to_list       = 6;
	localparam int opt_stream_buffer_source = 7;
	localparam int source_a                 = 8;

	// APB byte offsets
	localparam logic [11:0] REG_CMD_PUSH    = 12'h000;
	localparam logic [11:0] REG_CMD_RDPTR   = 12'h004;
	localparam logic [11:0] REG_CMD_WRPTR   = 12'h008;
	localparam logic [11:0] REG_STATUS      = 12'h00c;
	localparam logic [11:0] REG_PLAY_CTRL   = 12'h010;
	localparam logic [11:0] REG_STREAM_BASE = 12'h014;
	localparam logic [11:0] REG_STREAM_SIZE = 12'h018;
	localparam logic [11:0] REG_STREAM_RD   = 12'h01c;
	localparam logic [11:0] REG_STREAM_WR   = 12'h020;
	localparam logic [11:0] REG_FLASH_ADDR  = 12'h024;

	// status bits
	localparam int ST_BUSY   = 0;
	localparam int ST_ERROR  = 1;
	localparam int ST_REJECT = 2;

	// playback control values and reset
	localparam logic [7:0] PLAY_EXIT  = 8'hff;
	localparam logic [7:0] PLAY_PAUSE = 8'h00;
	localparam logic [7:0] PLAY_RUN   = 8'h01;

	// memory map of general RAM
	localparam logic [19:0] PNG_SCRATCH_BASE  = 20'hf5800;
	localparam logic [19:0] VIDEO_BITMAP_BASE = 20'h00000;
	localparam logic [19:0] AUDIO_BUF_BYTES   = 20'h08000;

	// bitmap formats
	localparam logic [2:0] FMT_NONE                = 3'h0;
	localparam logic [2:0] luminance_8bit_format   = 3'h1;
	localparam logic [2:0] color16_format          = 3'h2;
	localparam logic [2:0] paletted_color16_format = 3'h3;
	localparam logic [2:0] paletted_argb16_format  = 3'h4;
	localparam logic [2:0] argb_4bit_format        = 3'h5;

	// audio formats reported by the decoder
	localparam logic [1:0] AUD_PCM16 = 2'h3;

	typedef enum logic [1:0] {DL_NEW, DL_APPEND, DL_NONE} dl_mode_t;
	typedef enum logic [2:0] {K_DEFLATE, K_IMAGE, K_VIDEO, K_VIDHDR, K_FRAME} dec_kind_t;
	typedef enum logic [2:0] {C_RAW, C_SELECT, C_IMAGE, C_SETUP, C_PLAY, C_VSTART, C_VFRAME} cmd_t;
	typedef enum logic [2:0] {S_IDLE, S_ARGS, S_INLINE, S_STREAM} state_t;

endpackage : media_decode_pkg

// ---- media_decode_command_unit_sva.sv ----
// Purpose: port-level checks of the media command unit; Assumes: one clock; Notes: bound from tb top
`timescale 1ns/1ps
`default_nettype none
module media_decode_command_unit_sva
	import media_decode_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        memRdReq,
	input wire logic [31:0] memRdAddr,
	input wire logic        memRdAck,
	input wire logic        decWordValid,
	input wire logic        decWordReady,
	input wire logic [31:0] decWord,
	input wire logic        scratchActive,
	input wire logic [19:0] scratchAddr,
	input wire logic        audioOn,
	input wire logic [1:0]  audioFmt,
	input wire logic        audioDropLow,
	input wire logic        imgInfoValid,
	input wire logic        imgIsPng
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_apb_answer: assert property (psel && penable |-> ##[0:64] pready) else $error("apb access unanswered");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_mem_hold: assert property (memRdReq && !memRdAck |=> memRdReq && $stable(memRdAddr)) else $error("mem req dropped");
	a_word_hold: assert property (decWordValid && !decWordReady |=> decWordValid && $stable(decWord)) else $error("word dropped");
	a_scratch_base: assert property (scratchActive |-> scratchAddr == PNG_SCRATCH_BASE) else $error("scratch base");
	a_scratch_png: assert property ($rose(scratchActive) |-> $past(imgInfoValid) && $past(imgIsPng)) else $error("scratch without png");
	a_pcm16_drop: assert property ((audioOn && audioFmt == AUD_PCM16) [*3] |-> audioDropLow) else $error("pcm16 kept low");
	a_pcm8_keep: assert property ((audioOn && audioFmt != AUD_PCM16) [*3] |-> !audioDropLow) else $error("pcm8 dropped");
endmodule : media_decode_command_unit_sva
`default_nettype wire

// ---- decode_core_model.sv ----
// Purpose: decode core and memory responder; Assumes: same clock; Notes: stalls every other cycle
`timescale 1ns/1ps
`default_nettype none
module decode_core_model
	import media_decode_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        decStart,
	input  wire logic        decWordValid,
	input  wire logic        memRdReq,
	input  wire logic [31:0] memRdAddr,
	input  wire logic [2:0]  pngSel,
	input  wire logic        pngOn,
	output logic             decWordReady,
	output logic             decDone,
	output logic      [31:0] memRdData,
	output logic             memRdAck,
	output logic             imgInfoValid,
	output logic             imgIsPng,
	output logic      [2:0]  pngType,
	output logic             pngHasAlpha,
	output logic      [1:0]  audioFmt
);
	logic [3:0] cnt;
	assign imgIsPng = pngOn;
	assign pngType = pngSel;
	assign pngHasAlpha = 1'b0;
	assign audioFmt = AUD_PCM16;
	// slow ready so the unit must hold its word; done after four words
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{decWordReady, decDone, memRdAck, imgInfoValid, cnt} <= '0;
			memRdData <= 32'h0;
		end else begin
			decWordReady <= ~decWordReady;
			imgInfoValid <= decStart;
			memRdAck <= memRdReq && !memRdAck;
			memRdData <= memRdAck ? 32'h5a5a5a5a : ~memRdAddr; // released bus shows changing data
			cnt <= decStart ? 4'h0 : cnt + 4'(decWordValid && decWordReady);
			// one done pulse as the fourth word is taken, never a stale one from the last command
			decDone <= !decStart && decWordValid && decWordReady && (cnt == 4'h3);
		end
	end
endmodule : decode_core_model
`default_nettype wire

// ---- tb_media_decode_command_unit.sv ----
// Purpose: self-checking bench; Assumes: apb master; Notes: partner is decode_core_model
`timescale 1ns/1ps
`default_nettype none
module tb_media_decode_command_unit;
	import media_decode_pkg::*;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, vblankPin = 0, pngOn = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, memRdData, memRdAddr, q, q2;
	logic pready, pslverr, memRdReq, memRdAck, decWordValid, decWordReady, decDone, decStart, qe;
	logic imgInfoValid, imgIsPng, pngHasAlpha, scratchActive, audioOn, audioDropLow;
	logic [2:0] pngSel = 3'h0, pngType, bitmapFormat;
	logic [1:0] audioFmt;
	logic [19:0] scratchAddr;
	logic [31:0] decWord;
	int num_errors = 0, checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) vblankPin <= (cyc % 16) == 0;
	media_decode_command_unit dut_u (.clk, .rst, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .memRdReq, .memRdAddr, .memFlashSel(), .memRdData, .memRdAck, .decStart, .decKind(),
		.decDst(), .decAux(), .decWord, .decWordValid, .decWordReady, .decAbort(), .decDone, .imgInfoValid, .imgIsPng,
		.pngType, .pngHasAlpha, .audioFmt, .bitmapFormat, .scaleToScreen(), .dlMode(), .scratchActive, .scratchAddr,
		.audioOn, .audioGap(), .audioDropLow, .frameUpdateEn(), .vblankPin);
	decode_core_model core_u (.clk, .rst, .decStart, .decWordValid, .memRdReq, .memRdAddr, .pngSel, .pngOn,
		.decWordReady, .decDone, .memRdData, .memRdAck, .imgInfoValid, .imgIsPng, .pngType, .pngHasAlpha, .audioFmt);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		// look between edges so ready and data are settled; the next rising edge completes the transfer
		@(negedge clk);
		while (pready !== 1'b1) @(negedge clk);
		q = prdata;
		qe = pslverr;
		@(posedge clk);
		{psel, penable} <= 2'b00;
	endtask : apb
	// opcode and argument words then four inline words, then wait until the pointers meet
	task run_cmd(input logic [31:0] op, input logic [31:0] a1, input logic [31:0] a2);
		apb(1, REG_CMD_PUSH, op);
		apb(1, REG_CMD_PUSH, a1);
		if (op != OP_RAW_DECOMPRESS && op != OP_PLAY_VIDEO) apb(1, REG_CMD_PUSH, a2);
		for (int i = 0; i < 4; i++) apb(1, REG_CMD_PUSH, 32'h00000078 << i);
		for (int i = 0; i < 200; i++) begin
			apb(0, REG_CMD_RDPTR, 0);
			q2 = q;
			apb(0, REG_CMD_WRPTR, 0);
			if (q2 === q) break;
		end
		chk(q2, q);
	endtask : run_cmd
	task t_images;
		logic [2:0] fm [4] = '{luminance_8bit_format, color16_format, paletted_color16_format, argb_4bit_format};
		logic [2:0] ty [4] = '{3'h0, 3'h2, 3'h3, 3'h6};
		pngOn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			pngSel <= ty[i];
			run_cmd(OP_IMAGE_LOAD, 32'h1000, 32'h0);
			chk(32'(bitmapFormat), 32'(fm[i]));
		end
		pngOn <= 1'b0;
		run_cmd(OP_IMAGE_LOAD, 32'h1000, 32'h1 << opt_monochrome);
		chk(32'(bitmapFormat), 32'(luminance_8bit_format));
	endtask : t_images
	// no inline data follows the options, so only the exit value can end this playback
	task t_play;
		apb(1, REG_PLAY_CTRL, 32'(PLAY_RUN));
		apb(1, REG_CMD_PUSH, OP_PLAY_VIDEO);
		apb(1, REG_CMD_PUSH, 32'h1 << opt_decode_audio);
		repeat (8) @(posedge clk);
		apb(0, REG_STATUS, 0);
		chk(32'(q[ST_BUSY]), 32'h1);
		@(negedge clk);
		chk(32'(audioOn), 32'h1);
		chk(32'(audioDropLow), 32'h1);
		apb(1, REG_PLAY_CTRL, 32'(PLAY_EXIT));
		repeat (4) @(posedge clk);
		apb(0, REG_STATUS, 0);
		chk(32'(q[ST_BUSY]), 32'h0);
		@(negedge clk);
		chk(32'(audioOn), 32'h0);
		apb(0, 12'hffc, 0);
		chk(32'(qe), 32'h1);
	endtask : t_play
	task wrap_up;
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		run_cmd(OP_RAW_DECOMPRESS, 32'h8000, 32'h0);
		t_images();
		t_play();
		wrap_up();
	end
endmodule : tb_media_decode_command_unit
bind media_decode_command_unit media_decode_command_unit_sva sva_u (.clk, .rst, .psel, .penable, .pready,
	.pslverr, .memRdReq, .memRdAddr, .memRdAck, .decWordValid, .decWordReady, .decWord, .scratchActive, .scratchAddr,
	.audioOn, .audioFmt, .audioDropLow, .imgInfoValid, .imgIsPng);
`default_nettype wire
